// ===== nvs_cmd_unit.v
/*
 * Special-command unit of a serial nonvolatile memory slave: configuration,
 * identification, serial number, store/recall, autostore and clock registers.
 * Assumes a host in clock mode 0 or 3 with a serial clock well below ref_clk/4;
 * power_cycle is a one-cycle pulse from logic on ref_clk.
 */
`include "nvs_map.vh"
module nvs_cmd_unit #(
	parameter [10:0] MAKER_CODE = 11'h2A5, // arbitrary value
	parameter [13:0] PROD_CODE  = 14'h1234, // arbitrary value
	parameter [3:0]  DENS_CODE  = 4'h5, // arbitrary value
	parameter [2:0]  REV_CODE   = 3'h1, // arbitrary value
	parameter        SEQ_CYCLES = `NVS_SOFT_SEQ_NS / `NVS_CLK_PERIOD_NS
) (
	input  wire       ref_clk,
	input  wire       resetn,
	input  wire       cs_n,
	input  wire       sck,
	input  wire [3:0] io_in,
	input  wire       power_cycle,
	output reg  [3:0] io_out,
	output wire [3:0] io_oe,
	output wire       quad_width_bit,
	output wire       write_enable_latch,
	output wire       serial_num_lock,
	output wire       status_write_disable,
	output wire       autostore_en,
	output wire       busy,
	output wire       four_wire_mode,
	output wire       two_wire_mode,
	output reg        store_pulse,
	output reg        recall_pulse
);
	localparam [2:0] S_OP    = 3'h0;
	localparam [2:0] S_ADDR  = 3'h1;
	localparam [2:0] S_DUMMY = 3'h2;
	localparam [2:0] S_IN    = 3'h3;
	localparam [2:0] S_OUT   = 3'h4;
	localparam [2:0] S_IGN   = 3'h5;

	////////////////////////////////////////////////////////////////////////
	// helpers
	function [3:0] bits_per_clk;
		input [1:0] m;
		case (m)
			`NVS_MODE_DUAL: bits_per_clk = 4'h2;
			`NVS_MODE_QUAD: bits_per_clk = 4'h4;
			default:        bits_per_clk = 4'h1;
		endcase
	endfunction

	function [7:0] shift_in;
		input [7:0] s;
		input [3:0] d;
		input [1:0] m;
		case (m)
			`NVS_MODE_DUAL: shift_in = {s[5:0], d[1:0]};
			`NVS_MODE_QUAD: shift_in = {s[3:0], d};
			default:        shift_in = {s[6:0], d[0]};
		endcase
	endfunction

	// single width answers on io[1], the others from io[0] up
	function [3:0] lane_out;
		input [7:0] t;
		input [1:0] m;
		case (m)
			`NVS_MODE_DUAL: lane_out = {2'h0, t[7:6]};
			`NVS_MODE_QUAD: lane_out = t[7:4];
			default:        lane_out = {2'h0, t[7], 1'b0};
		endcase
	endfunction

	function [3:0] lane_mask;
		input [1:0] m;
		case (m)
			`NVS_MODE_DUAL: lane_mask = 4'h3;
			`NVS_MODE_QUAD: lane_mask = 4'hF;
			default:        lane_mask = 4'h2;
		endcase
	endfunction

	function needs_latch;
		input [7:0] op;
		case (op)
			`NVS_OP_SR_WRITE, `NVS_OP_CR_WRITE, `NVS_OP_SN_WRITE, `NVS_OP_STORE,
			`NVS_OP_RECALL, `NVS_OP_AS_ON, `NVS_OP_AS_OFF, `NVS_OP_CLK_WRITE:
				needs_latch = 1'b1;
			default:
				needs_latch = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; chip select idles high
	wire       cs_s;
	wire       sck_s;
	wire [3:0] io_s;

	nvs_sync #(.W(6), .INIT(6'h20)) u_sync (
		.clk    (ref_clk),
		.resetn (resetn),
		.din    ({cs_n, sck, io_in}),
		.dout   ({cs_s, sck_s, io_s})
	);

	reg        cs_q_ff;
	reg        sck_q_ff;
	reg [2:0]  st_ff;
	reg [7:0]  cmd_ff;
	reg [7:0]  sh_ff;
	reg [3:0]  cnt_ff;
	reg [3:0]  ptr_ff;
	reg [7:0]  tx_ff;
	reg [3:0]  ocnt_ff;
	reg [7:0]  db_ff;
	reg        got_ff;
	reg [1:0]  mode_ff;
	reg        wel_ff;
	reg [7:0]  sr_ff;
	reg [7:0]  nv_sr_ff;
	reg [7:0]  cr_ff;
	reg        as_ff;
	reg        nv_as_ff;
	reg [7:0]  sn_ff [0:7];
	reg [7:0]  nv_sn_ff [0:7];
	reg [7:0]  clk_ff [0:15];
	reg [7:0]  clk_buf_ff [0:15];
	reg [7:0]  tx_src;
	integer    i;

	wire        sck_rise = sck_s & ~sck_q_ff;
	wire        sck_fall = ~sck_s & sck_q_ff;
	wire        cs_rise  = cs_s & ~cs_q_ff;
	wire        cs_fall  = ~cs_s & cs_q_ff;
	wire [3:0]  nxt_cnt  = cnt_ff + bits_per_clk(mode_ff);
	wire        rx_done  = sck_rise & ~cs_s & (nxt_cnt == `NVS_BYTE_BITS);
	wire [7:0]  nxt_byte = shift_in(sh_ff, io_s, mode_ff);
	wire        dec      = rx_done & (st_ff == S_OP);
	wire        in_done  = rx_done & (st_ff == S_IN);
	wire        seq_busy;
	wire        stored_lock = nv_sr_ff[`NVS_SR_LOCK];
	wire [31:0] id_word = {MAKER_CODE, PROD_CODE, DENS_CODE, REV_CODE};
	wire        pc_store  = power_cycle & as_ff;
	wire        pc_reload = power_cycle & ~as_ff;
	wire        do_store  = pc_store | (cs_rise & (cmd_ff == `NVS_OP_STORE));
	wire        clk_snap  = dec & ~seq_busy & ((nxt_byte == `NVS_OP_CLK_READ) | (nxt_byte == `NVS_OP_CLK_WRITE));
	wire        clk_commit = cs_rise & (cmd_ff == `NVS_OP_CLK_WRITE) & got_ff;
	wire        as_start = cs_rise & ((cmd_ff == `NVS_OP_AS_ON) | (cmd_ff == `NVS_OP_AS_OFF));

	nvs_busy_timer #(.CYCLES(SEQ_CYCLES), .CW(16)) u_busy (
		.clk    (ref_clk),
		.resetn (resetn),
		.start  (as_start),
		.busy   (seq_busy)
	);

	////////////////////////////////////////////////////////////////////////
	// byte that the read in progress shifts out next
	always @* begin
		case (cmd_ff)
			`NVS_OP_ID_READ, `NVS_OP_ID_FAST:
				tx_src = id_word[{~ptr_ff[1:0], 3'h0} +: 8];
			`NVS_OP_SN_READ, `NVS_OP_SN_FAST:
				tx_src = sn_ff[ptr_ff[2:0]];
			`NVS_OP_CLK_READ:
				tx_src = clk_buf_ff[ptr_ff];
			`NVS_OP_SR_READ:
				tx_src = {sr_ff[7:2], wel_ff, seq_busy};
			default:
				tx_src = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// frame sequencer on serial clock rising edges; read pointer steps on falling edges
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cs_q_ff  <= 1'b1;
			sck_q_ff <= 1'b0;
			st_ff    <= S_OP;
			cmd_ff   <= `NVS_OP_NONE;
			sh_ff    <= 8'h00;
			cnt_ff   <= 4'h0;
			ptr_ff   <= 4'h0;
			db_ff    <= 8'h00;
			got_ff   <= 1'b0;
		end else begin
			cs_q_ff  <= cs_s;
			sck_q_ff <= sck_s;
			if (cs_fall) begin
				st_ff  <= S_OP;
				cnt_ff <= 4'h0;
				got_ff <= 1'b0;
				cmd_ff <= `NVS_OP_NONE;
			end else if (sck_rise & ~cs_s) begin
				sh_ff  <= nxt_byte;
				cnt_ff <= rx_done ? 4'h0 : nxt_cnt;
				if (rx_done) begin
					case (st_ff)
						S_OP: begin
							ptr_ff <= 4'h0;
							if (seq_busy || (needs_latch(nxt_byte) && !wel_ff)) begin
								st_ff  <= S_IGN;
								cmd_ff <= `NVS_OP_NONE;
							end else begin
								cmd_ff <= nxt_byte;
								case (nxt_byte)
									`NVS_OP_ID_READ, `NVS_OP_SN_READ, `NVS_OP_SR_READ:
										st_ff <= S_OUT;
									`NVS_OP_ID_FAST, `NVS_OP_SN_FAST:
										st_ff <= S_DUMMY;
									`NVS_OP_CLK_READ, `NVS_OP_CLK_WRITE:
										st_ff <= S_ADDR;
									`NVS_OP_SN_WRITE, `NVS_OP_SR_WRITE, `NVS_OP_CR_WRITE:
										st_ff <= S_IN;
									default:
										st_ff <= S_IGN;
								endcase
							end
						end
						S_ADDR: begin
							// clock space holds sixteen bytes only
							ptr_ff <= nxt_byte[3:0];
							st_ff  <= (cmd_ff == `NVS_OP_CLK_READ) ? S_OUT : S_IN;
						end
						S_DUMMY:
							st_ff <= S_OUT;
						S_IN: begin
							db_ff  <= nxt_byte;
							got_ff <= 1'b1;
							// pointer wraps in its own width
							ptr_ff <= ptr_ff + 4'h1;
						end
						default:
							st_ff <= st_ff;
					endcase
				end
			end else if (sck_fall & ~cs_s & (st_ff == S_OUT) &
				(ocnt_ff + bits_per_clk(mode_ff) == `NVS_BYTE_BITS))
				ptr_ff <= ptr_ff + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// answer shifter on serial clock falling edges
	wire [7:0] cur_tx = (ocnt_ff == 4'h0) ? tx_src : tx_ff;

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_ff   <= 8'h00;
			ocnt_ff <= 4'h0;
			io_out  <= 4'h0;
		end else if (cs_s | (st_ff != S_OUT)) begin
			ocnt_ff <= 4'h0;
			io_out  <= 4'h0;
		end else if (sck_fall) begin
			io_out  <= lane_out(cur_tx, mode_ff);
			tx_ff   <= shift_in(cur_tx, 4'h0, mode_ff);
			ocnt_ff <= (ocnt_ff + bits_per_clk(mode_ff) == `NVS_BYTE_BITS) ? 4'h0 :
				ocnt_ff + bits_per_clk(mode_ff);
		end
	end

	assign io_oe = (~cs_s & (st_ff == S_OUT)) ? lane_mask(mode_ff) : 4'h0;

	////////////////////////////////////////////////////////////////////////
	// commit at chip select rising edge, power cycle and store
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_ff      <= `NVS_MODE_SINGLE;
			wel_ff       <= 1'b0;
			sr_ff        <= `NVS_SR_RESET;
			nv_sr_ff     <= `NVS_SR_RESET;
			cr_ff        <= `NVS_CR_RESET;
			as_ff        <= 1'b1;
			nv_as_ff     <= 1'b1;
			store_pulse  <= 1'b0;
			recall_pulse <= 1'b0;
		end else begin
			store_pulse  <= do_store;
			recall_pulse <= 1'b0;
			if (do_store) begin
				nv_sr_ff <= sr_ff;
				nv_as_ff <= as_ff;
			end
			if (pc_reload) begin
				// no automatic store: volatile settings fall back
				sr_ff  <= nv_sr_ff;
				as_ff  <= nv_as_ff;
				wel_ff <= 1'b0;
			end else if (power_cycle) begin
				wel_ff <= 1'b0;
			end else if (cs_rise) begin
				case (cmd_ff)
					`NVS_OP_WR_ENABLE:
						wel_ff <= 1'b1;
					`NVS_OP_STORE:
						wel_ff <= 1'b0;
					`NVS_OP_RECALL: begin
						recall_pulse <= 1'b1;
						wel_ff       <= 1'b0;
					end
					`NVS_OP_AS_ON: begin
						as_ff  <= 1'b1;
						wel_ff <= 1'b0;
					end
					`NVS_OP_AS_OFF: begin
						as_ff  <= 1'b0;
						wel_ff <= 1'b0;
					end
					`NVS_OP_QUAD_ENTER:
						mode_ff <= `NVS_MODE_QUAD;
					`NVS_OP_DUAL_ENTER:
						mode_ff <= `NVS_MODE_DUAL;
					`NVS_OP_SINGLE_BACK:
						mode_ff <= `NVS_MODE_SINGLE;
					`NVS_OP_SN_WRITE:
						if (got_ff && !sr_ff[`NVS_SR_WDIS])
							wel_ff <= 1'b0;
					`NVS_OP_SR_WRITE:
						if (got_ff) begin
							// a status write can never take back a stored lock
							sr_ff <= (db_ff & `NVS_SR_WR_MASK) |
								({7'h00, stored_lock} << `NVS_SR_LOCK);
							wel_ff <= 1'b0;
						end
					`NVS_OP_CR_WRITE:
						if (got_ff) begin
							cr_ff  <= db_ff;
							wel_ff <= 1'b0;
						end
					`NVS_OP_CLK_WRITE:
						if (got_ff)
							wel_ff <= 1'b0;
					default:
						wel_ff <= wel_ff;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial number bytes, volatile copy and stored copy; no checksum kept
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < 8; i = i + 1)
				sn_ff[i] <= `NVS_SN_RESET;
		end else if (pc_reload) begin
			for (i = 0; i < 8; i = i + 1)
				sn_ff[i] <= nv_sn_ff[i];
		end else if (in_done && (cmd_ff == `NVS_OP_SN_WRITE) && !sr_ff[`NVS_SR_LOCK]) begin
			sn_ff[ptr_ff[2:0]] <= nxt_byte;
		end
	end

	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < 8; i = i + 1)
				nv_sn_ff[i] <= `NVS_SN_RESET;
		end else if (do_store) begin
			for (i = 0; i < 8; i = i + 1)
				nv_sn_ff[i] <= sn_ff[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clock registers: user buffer snapshots the live set at the opcode,
	// so a frame never sees a value change mid-burst
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < 16; i = i + 1)
				clk_buf_ff[i] <= `NVS_CLK_RESET;
		end else if (clk_snap) begin
			for (i = 0; i < 16; i = i + 1)
				clk_buf_ff[i] <= clk_ff[i];
		end else if (in_done && (cmd_ff == `NVS_OP_CLK_WRITE)) begin
			clk_buf_ff[ptr_ff] <= nxt_byte;
		end
	end

	// whole set moves at once when the write frame ends
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < 16; i = i + 1)
				clk_ff[i] <= `NVS_CLK_RESET;
		end else if (clk_commit) begin
			for (i = 0; i < 16; i = i + 1)
				clk_ff[i] <= clk_buf_ff[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// visible state
	assign quad_width_bit       = cr_ff[`NVS_CR_QUAD];
	assign write_enable_latch   = wel_ff;
	assign serial_num_lock      = sr_ff[`NVS_SR_LOCK];
	assign status_write_disable = sr_ff[`NVS_SR_WDIS];
	assign autostore_en         = as_ff;
	assign busy                 = seq_busy;
	assign four_wire_mode       = (mode_ff == `NVS_MODE_QUAD);
	assign two_wire_mode        = (mode_ff == `NVS_MODE_DUAL);
endmodule

// ===== nvs_map.vh
/*
 * Constants of the special-command unit: opcodes, status and configuration
 * bit positions, identification fields, reset values and timing.
 * Assumes it is included by bare name from the design files.
 */
// How it works
// - four-wire entry leaves quad bit alone
// - identification read: four bytes, MSB first
// - two-bit id pointer, cleared, wraps three
// - fast id read has one dummy byte
// - id fields: maker, product, density, revision
// - eight serial bytes, zero default, no checksum
// - serial write needs latch, wraps to first
// - lock bit freezes the serial number
// - serial write clears latch unless write-disable
// - unstored lock reverts; stored lock stays set
// - plain serial read bursts eight bytes, wraps
// - fast serial read has one dummy byte
// - store always copies when latch set
// - latch cleared at end of nv commands
// - recall pulses recall_pulse when latch set, reloads nothing itself
// - autostore on after reset, commands change it
// - autostore commands make device busy a while
// - clock registers: own space, sixteen addresses
// - clock registers double-buffered, held as BCD
// - lock is status bit 6, disable bit 7
`ifndef NVS_MAP_VH
`define NVS_MAP_VH
////////////////////////////////////////////////////////////////////////////////
// opcodes
`define NVS_OP_NONE        8'h00
`define NVS_OP_WR_ENABLE   8'h06
`define NVS_OP_SR_WRITE    8'h01
`define NVS_OP_SR_READ     8'h05
`define NVS_OP_CR_WRITE    8'h87
`define NVS_OP_ID_READ     8'h9F
`define NVS_OP_ID_FAST     8'h99
`define NVS_OP_SN_WRITE    8'hC2
`define NVS_OP_SN_READ     8'hC3
`define NVS_OP_SN_FAST     8'hC9
`define NVS_OP_STORE       8'h8C
`define NVS_OP_RECALL      8'h60
`define NVS_OP_AS_ON       8'h59
`define NVS_OP_AS_OFF      8'h19
`define NVS_OP_QUAD_ENTER  8'h38
`define NVS_OP_DUAL_ENTER  8'h37
`define NVS_OP_SINGLE_BACK 8'hFF
`define NVS_OP_CLK_READ    8'h13
`define NVS_OP_CLK_WRITE   8'h12
////////////////////////////////////////////////////////////////////////////////
// transfer widths
`define NVS_MODE_SINGLE 2'h0
`define NVS_MODE_DUAL   2'h1
`define NVS_MODE_QUAD   2'h2
`define NVS_BYTE_BITS   4'h8
////////////////////////////////////////////////////////////////////////////////
// status and configuration bits
`define NVS_SR_BUSY     0
`define NVS_SR_WEL      1
`define NVS_SR_LOCK     6
`define NVS_SR_WDIS     7
`define NVS_SR_WR_MASK  8'hFC
`define NVS_SR_RESET    8'h00
`define NVS_CR_QUAD     1
`define NVS_CR_RESET    8'h00
`define NVS_SN_RESET    8'h00
`define NVS_CLK_RESET   8'h00
////////////////////////////////////////////////////////////////////////////////
// identification word fields
`define NVS_ID_MAKER_LSB 21
`define NVS_ID_PROD_LSB  7
`define NVS_ID_DENS_LSB  3
////////////////////////////////////////////////////////////////////////////////
// timing
`define NVS_CLK_PERIOD_NS 10
`define NVS_SOFT_SEQ_NS   100000
`endif

// ===== nvs_sync.v
/*
 * Two-stage synchroniser for a bundle of pin levels.
 * Assumes each bit is an independent slow level relative to clk.
 */
`include "nvs_map.vh"
module nvs_sync #(
	parameter         W    = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input  wire         clk,
	input  wire         resetn,
	input  wire [W-1:0] din,
	output wire [W-1:0] dout
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	////////////////////////////////////////////////////////////////////////
	// first stage is read only by the second
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= INIT;
			sync_ff <= INIT;
		end else begin
			meta_ff <= din;
			sync_ff <= meta_ff;
		end
	end
	assign dout = sync_ff;
endmodule

// ===== nvs_busy_timer.v
/*
 * Busy timer for the soft sequence time after autostore commands.
 * Assumes start is a one-cycle pulse on clk.
 */
`include "nvs_map.vh"
module nvs_busy_timer #(
	parameter CYCLES = 1,
	parameter CW     = 16
) (
	input  wire clk,
	input  wire resetn,
	input  wire start,
	output wire busy
);
	reg [CW-1:0] cnt_ff;

	////////////////////////////////////////////////////////////////////////
	// load on start, count down to zero; restart extends the window
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			cnt_ff <= {CW{1'b0}};
		else if (start)
			cnt_ff <= CYCLES[CW-1:0];
		else if (cnt_ff != {CW{1'b0}})
			cnt_ff <= cnt_ff - {{(CW-1){1'b0}}, 1'b1};
	end
	assign busy = (cnt_ff != {CW{1'b0}});
endmodule

// ===== nvs_checker.sv
/*
 * Concurrent checks on the ports of the special-command unit.
 * Assumes one clock domain (ref_clk) and resetn active low, asynchronous.
 */
module nvs_checker #(
	parameter int SEQ_CYCLES = 10000
) (
	input wire       ref_clk,
	input wire       resetn,
	input wire       cs_n,
	input wire       sck,
	input wire [3:0] io_in,
	input wire       power_cycle,
	input wire [3:0] io_out,
	input wire [3:0] io_oe,
	input wire       quad_width_bit,
	input wire       write_enable_latch,
	input wire       serial_num_lock,
	input wire       status_write_disable,
	input wire       autostore_en,
	input wire       busy,
	input wire       four_wire_mode,
	input wire       two_wire_mode,
	input wire       store_pulse,
	input wire       recall_pulse
);
	logic [15:0] busy_len_ff;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	////////////////////////////////////////
	// length of the current busy stretch, read back when busy drops
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			busy_len_ff <= 16'h0000;
		else if (busy)
			busy_len_ff <= busy_len_ff + 16'h0001;
		else
			busy_len_ff <= 16'h0000;
	end
	// sync delay of cs_n is why six samples are allowed
	oe_idle_a: assert property (cs_n [*6] |-> io_oe == 4'h0)
		else $error("output enabled while deselected");
	out_hold_a: assert property (sck [*6] |-> $stable(io_out))
		else $error("read data moved while clock high");
	wel_fall_a: assert property ($fell(write_enable_latch) |-> cs_n || $past(power_cycle))
		else $error("latch cleared inside a frame");
	wel_rise_a: assert property ($rose(write_enable_latch) |-> cs_n && !$past(busy))
		else $error("latch set while busy");
	recall_wel_a: assert property (recall_pulse |-> $past(write_enable_latch) && !write_enable_latch)
		else $error("recall without latch or latch kept");
	store_wel_a: assert property (store_pulse |-> $past(write_enable_latch) || $past(power_cycle) ||
		$past(power_cycle, 2))
		else $error("store without latch");
	busy_len_a: assert property ($fell(busy) |-> 32'(busy_len_ff) == SEQ_CYCLES)
		else $error("busy stretch has wrong length");
	busy_start_a: assert property ($rose(busy) |-> $past(write_enable_latch) && !write_enable_latch)
		else $error("busy without latch command");
	quad_keep_a: assert property ($changed(quad_width_bit) |-> $past(write_enable_latch) && cs_n)
		else $error("quad bit changed without config write");
	four_quad_a: assert property ($rose(four_wire_mode) |-> $stable(quad_width_bit))
		else $error("four-wire entry touched quad bit");
	as_keep_a: assert property ($changed(autostore_en) |-> $past(write_enable_latch) ||
		$past(power_cycle) || $past(power_cycle, 2))
		else $error("autostore changed without latch");
	lock_set_a: assert property ($rose(serial_num_lock) |-> $past(write_enable_latch))
		else $error("lock set without latch");
endmodule

// ===== nvs_host.sv
/*
 * Host serial controller model, single, dual or quad width, clock mode 0.
 * Assumes the bench calls its tasks; link clock period 160 ns.
 */
module nvs_host (
	output logic       cs_n,
	output logic       sck,
	output logic [3:0] io_in,
	input  wire  [3:0] io_out
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 80; // 6.25 MHz, far below the plain read limit
	int            w    = 1; // bits per clock: 1, 2 or 4, set by the bench
	////////////////////////////////////////
	// clock stands low between frames
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		io_in = 4'hF;
	end
	task automatic start_f();
		#HALF;
		cs_n = 1'b0;
		#HALF;
	endtask
	// released lane shows the inverse so a stale bit is never read as good
	task automatic end_f();
		#HALF;
		cs_n = 1'b1;
		io_in = ~io_in;
		#(5 * HALF);
	endtask
	// host side of the opcode and data phases, msb first
	task automatic tx(input logic [7:0] b);
		for (int i = 8 - w; i >= 0; i = i - w) begin
			io_in = 4'(b >> i) & 4'((1 << w) - 1);
			#HALF sck = 1'b1;
			#HALF sck = 1'b0;
		end
	endtask
	// single width answers on io[1], wider modes from io[0] up
	task automatic rx(output logic [7:0] b);
		for (int i = 8 - w; i >= 0; i = i - w) begin
			#HALF sck = 1'b1;
			b = (w == 1) ? {b[6:0], io_out[1]} : (b << w) | 8'(io_out & 4'((1 << w) - 1));
			#HALF sck = 1'b0;
		end
	endtask
endmodule

// ===== nvs_cmd_unit_tb.sv
/*
 * Self-checking bench for the special-command unit driven by the host model.
 * Assumes nvs_map.vh, nvs_host and nvs_checker are compiled beforehand.
 */
`include "nvs_map.vh"
module nvs_cmd_unit_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int          SEQ = 200;
	localparam logic [31:0] ID  = {11'h155, 14'h0ACE, 4'h9, 3'h2}; // arbitrary codes
	logic        ref_clk;
	logic        resetn;
	logic        power_cycle;
	wire         cs_n;
	wire         sck;
	wire  [3:0]  io_in;
	wire  [3:0]  io_out;
	wire  [3:0]  io_oe;
	wire         quad_width_bit, write_enable_latch, serial_num_lock, status_write_disable;
	wire         autostore_en, busy, four_wire_mode, two_wire_mode, store_pulse, recall_pulse;
	wire  [7:0]  flags;
	int          bad_count;
	int          total_checks;
	int          n_store;
	int          n_recall;
	logic [63:0] res;
	logic [3:0]  oe_exp = 4'h2;
	assign flags = {quad_width_bit, write_enable_latch, serial_num_lock, status_write_disable,
		autostore_en, busy, four_wire_mode, two_wire_mode};
	nvs_cmd_unit #(.MAKER_CODE(11'h155), .PROD_CODE(14'h0ACE), .DENS_CODE(4'h9), .REV_CODE(3'h2),
		.SEQ_CYCLES(SEQ)) u_nvs_cmd_unit (.ref_clk, .resetn, .cs_n, .sck, .io_in, .power_cycle,
		.io_out, .io_oe, .quad_width_bit, .write_enable_latch, .serial_num_lock, .status_write_disable,
		.autostore_en, .busy, .four_wire_mode, .two_wire_mode, .store_pulse, .recall_pulse);
	nvs_host u_nvs_host (.cs_n, .sck, .io_in, .io_out);
	////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// pulse counters, so no pulse can slip by between checks
	always @(posedge ref_clk) begin
		if (store_pulse === 1'b1) n_store++;
		if (recall_pulse === 1'b1) n_recall++;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] op, input int dum, input int n);
		logic [7:0] b;
		res = 64'h0;
		u_nvs_host.start_f();
		u_nvs_host.tx(op);
		repeat (dum) u_nvs_host.rx(b);
		for (int i = 0; i < n; i++) begin
			u_nvs_host.rx(b);
			res = {res[55:0], b};
		end
		chk(io_oe, oe_exp);
		u_nvs_host.end_f();
	endtask
	task automatic wr(input logic [7:0] op, input int n, input logic [63:0] d);
		u_nvs_host.start_f();
		u_nvs_host.tx(op);
		for (int i = n - 1; i >= 0; i--) u_nvs_host.tx(d[8*i +: 8]);
		u_nvs_host.end_f();
	endtask
	task automatic we_wr(input logic [7:0] op, input int n, input logic [63:0] d);
		wr(`NVS_OP_WR_ENABLE, 0, 64'h0);
		wr(op, n, d);
	endtask
	task automatic do_reset();
		resetn = 1'b0;
		repeat (20) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (5) @(negedge ref_clk);
	endtask
	task automatic pulse_power();
		@(negedge ref_clk) power_cycle = 1'b1;
		@(negedge ref_clk) power_cycle = 1'b0;
		repeat (10) @(negedge ref_clk);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 500 && busy !== 1'b0; i++) @(negedge ref_clk);
		chk(busy, 1'b0);
	endtask
	////////////////////////////////////////
	task automatic t_ident();
		rd(`NVS_OP_ID_READ, 0, 5);
		chk(res[39:0], {ID, ID[31:24]});
		rd(`NVS_OP_ID_FAST, 1, 4);
		chk(res[31:0], ID);
	endtask
	task automatic t_serial();
		rd(`NVS_OP_SN_READ, 0, 8);
		chk(res, 64'h0);
		wr(`NVS_OP_SN_WRITE, 2, 64'hA5A5);
		rd(`NVS_OP_SN_READ, 0, 8);
		chk(res, 64'h0);
		wr(`NVS_OP_WR_ENABLE, 0, 64'h0);
		u_nvs_host.start_f();
		u_nvs_host.tx(`NVS_OP_SN_WRITE);
		for (int i = 1; i <= 9; i++) u_nvs_host.tx(8'(i * 17));
		u_nvs_host.end_f();
		chk(write_enable_latch, 1'b0);
		rd(`NVS_OP_SN_READ, 0, 9);
		chk(res, 64'h2233445566778899);
		rd(`NVS_OP_SN_FAST, 1, 8);
		chk(res, 64'h9922334455667788);
	endtask
	task automatic t_nv();
		int s;
		s = n_store;
		wr(`NVS_OP_STORE, 0, 64'h0);
		chk(n_store, s);
		for (int i = 1; i <= 2; i++) begin
			we_wr(`NVS_OP_STORE, 0, 64'h0);
			chk(n_store, s + i);
			chk(write_enable_latch, 1'b0);
		end
		wr(`NVS_OP_RECALL, 0, 64'h0);
		chk(n_recall, 0);
		we_wr(`NVS_OP_RECALL, 0, 64'h0);
		chk(n_recall, 1);
		we_wr(`NVS_OP_AS_OFF, 0, 64'h0);
		chk(flags, 8'h04);
		wr(`NVS_OP_WR_ENABLE, 0, 64'h0);
		chk(write_enable_latch, 1'b0);
		wait_idle();
		we_wr(`NVS_OP_AS_ON, 0, 64'h0);
		chk(flags, 8'h0C);
		wait_idle();
	endtask
	task automatic t_lock();
		int s;
		we_wr(`NVS_OP_AS_OFF, 0, 64'h0);
		wait_idle();
		we_wr(`NVS_OP_SR_WRITE, 1, 64'h40);
		chk(serial_num_lock, 1'b1);
		we_wr(`NVS_OP_SN_WRITE, 1, 64'hEE);
		rd(`NVS_OP_SN_READ, 0, 8);
		chk(res, 64'h9922334455667788);
		pulse_power();
		chk(flags, 8'h08);
		we_wr(`NVS_OP_SR_WRITE, 1, 64'hC0);
		s = n_store;
		we_wr(`NVS_OP_STORE, 0, 64'h0);
		chk(flags, 8'h38);
		we_wr(`NVS_OP_SN_WRITE, 1, 64'hEE);
		chk(write_enable_latch, 1'b1);
		wr(`NVS_OP_SR_WRITE, 1, 64'h00);
		chk(serial_num_lock, 1'b1);
		pulse_power();
		chk(serial_num_lock, 1'b1);
		chk(n_store, s + 2);
		rd(`NVS_OP_SN_READ, 0, 8);
		chk(res, 64'h9922334455667788);
	endtask
	task automatic t_quad();
		wr(`NVS_OP_CR_WRITE, 1, 64'h02);
		chk(quad_width_bit, 1'b0);
		we_wr(`NVS_OP_CR_WRITE, 1, 64'h02);
		chk(quad_width_bit, 1'b1);
		wr(`NVS_OP_DUAL_ENTER, 0, 64'h0);
		chk(two_wire_mode, 1'b1);
		u_nvs_host.w = 2;
		oe_exp = 4'h3;
		rd(`NVS_OP_SN_READ, 0, 8);
		chk(res, 64'h9922334455667788);
		wr(`NVS_OP_SINGLE_BACK, 0, 64'h0);
		u_nvs_host.w = 1;
		wr(`NVS_OP_QUAD_ENTER, 0, 64'h0);
		chk({quad_width_bit, four_wire_mode}, 2'b11);
		// quad bit was set above, but four-wire reads do not depend on it
		u_nvs_host.w = 4;
		oe_exp = 4'hF;
		rd(`NVS_OP_ID_FAST, 1, 4);
		chk(res[31:0], ID);
		do_reset();
		u_nvs_host.w = 1;
		oe_exp = 4'h2;
		chk(flags, 8'h08);
	endtask
	// write at the top address wraps to zero; read snapshot sees the commit
	task automatic t_clock();
		logic [7:0] b;
		we_wr(`NVS_OP_CLK_WRITE, 3, 64'h0F1234);
		chk(write_enable_latch, 1'b0);
		u_nvs_host.start_f();
		u_nvs_host.tx(`NVS_OP_CLK_READ);
		u_nvs_host.tx(8'h0F);
		u_nvs_host.rx(b);
		chk(b, 8'h12);
		u_nvs_host.rx(b);
		chk(b, 8'h34);
		u_nvs_host.end_f();
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		power_cycle = 1'b0;
		do_reset();
		chk(flags, 8'h08);
		t_ident();
		t_serial();
		t_nv();
		t_lock();
		t_clock();
		t_quad();
		print_verdict();
	end
	// run needs about 210 us; a hang is cut at 800 us, 80k cycles
	initial begin
		#800us;
		bad_count++;
		print_verdict();
	end
endmodule
bind nvs_cmd_unit nvs_checker #(.SEQ_CYCLES(SEQ_CYCLES)) u_nvs_checker (.ref_clk, .resetn, .cs_n, .sck,
	.io_in, .power_cycle, .io_out, .io_oe, .quad_width_bit, .write_enable_latch, .serial_num_lock,
	.status_write_disable, .autostore_en, .busy, .four_wire_mode, .two_wire_mode, .store_pulse,
	.recall_pulse);
